// ==== hdl/mcw_cfg.svh ====
`ifndef MCW_CFG_SVH
`define MCW_CFG_SVH

// ****************************************
// Register offsets on the AXI4-Lite bus
// ****************************************
`define MCW_OFS_CTL 8'h00
`define MCW_OFS_CMD 8'h04
`define MCW_OFS_RDC 8'h08
`define MCW_OFS_DREG 8'h0c
`define MCW_OFS_DIAR 8'h10

// ****************************************
// Command word fields (bit n of the word is index 15-n)
// ****************************************
`define MCW_CMD_RSEL_LSB 0
`define MCW_CMD_READ 4
`define MCW_CMD_SYNC 6

// ****************************************
// Control word fields
// ****************************************
`define MCW_CTL_SWEEP 15
`define MCW_CTL_IGATE 14
`define MCW_CTL_NOOVL 13
`define MCW_CTL_CHSEL_LSB 11
`define MCW_CTL_ADJ 10
`define MCW_CTL_DEC 9
`define MCW_CTL_INC 8
`define MCW_CTL_TRAIL 7
`define MCW_CTL_LEAD 6
`define MCW_CTL_MOVE 5
`define MCW_CTL_PANEL_LSB 0

// ****************************************
// Read/status register fields
// ****************************************
`define MCW_RDC_GO 0
`define MCW_RDC_DONE 1
`define MCW_RDC_BUSY 0
`define MCW_RDC_CHSEL_LSB 4
`define MCW_RDC_PANEL_LSB 8

// ****************************************
// Reset values and timing
// ****************************************
`define MCW_CMD_RST 16'h0000
`define MCW_CTL_RST 16'h0000
`define MCW_READ_SETUP 4'h2
`define MCW_SYNC_HOLD 4'h2
`define MCW_RESP_OKAY 2'h0
`define MCW_RESP_SLVERR 2'h2

`endif

// ==== hdl/mcw_pkg.sv ====
`default_nettype none
package mcw_pkg;

   typedef enum logic [1:0] {
      MCW_CH_NONE,
      MCW_CH_ONE,
      MCW_CH_TWO,
      MCW_CH_THREE
   } mcw_chsel_t;

   typedef enum logic [2:0] {
      MCW_PNL_ALL,
      MCW_PNL_FLOAT,
      MCW_PNL_STORAGE,
      MCW_PNL_STREAM,
      MCW_PNL_UNUSED,
      MCW_PNL_DAC,
      MCW_PNL_SINGLE
   } mcw_panel_t;

   typedef enum logic [2:0] {
      MCW_RD_IDLE,
      MCW_RD_STROBE,
      MCW_RD_SYNC,
      MCW_RD_CAPTURE,
      MCW_RD_RELEASE
   } mcw_rd_state_t;

endpackage : mcw_pkg
`default_nettype wire

// ==== hdl/mcw_host.sv ====
// Functional notes
// - Control bit 0 makes instructions passes
// - Control bit 1 gates interrupts to boundaries
// - Control bit 2 blocks execution overlap
// - Control bits 3-4 select channel register
// - Clock margins act only with bit 5
// - Control bit 6 lowers clock frequency
// - Control bit 7 raises clock frequency
// - Control bit 8 delays trailing clock edge
// - Control bit 9 delays leading clock edge
// - Bit A picks even or odd clocks
// - Bits B-F form panel designator, B MSB
// - Designator 00 all, 03 stream, 05 DAC
// - Read strobe returns register and instruction address
// - Sync rises only after read is set
`timescale 1ns/1ps
`default_nettype none
`include "mcw_cfg.svh"

module mcw_host
   import mcw_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int REG_W = 32,
   parameter int IAR_W = 32
) (
   input wire logic aclk, // Clock, 50 MHz
   input wire logic aresetn, // Synchronous reset, low
   input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
   input wire logic [2:0] s_axi_awprot, // Write protection, unused
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
   input wire logic [2:0] s_axi_arprot, // Read protection, unused
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   output logic [15:0] maint_command_word, // Command word to CPU
   output logic [15:0] maint_control_word, // Control word to CPU
   input wire logic [REG_W-1:0] disp_reg_data, // Selected CPU register
   input wire logic [IAR_W-1:0] current_instr_address // Instruction address
);

   // ****************************************
   // Helper functions
   // ****************************************
   function automatic logic [15:0] apply_strb(input logic [15:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
      logic [15:0] res;
      res = old;
      if (strb[0]) begin
         res[7:0] = data[7:0];
      end
      if (strb[1]) begin
         res[15:8] = data[15:8];
      end
      return res;
   endfunction : apply_strb

   function automatic mcw_panel_t panel_class(input logic [4:0] code);
      mcw_panel_t res;
      case (code)
         5'h00: res = MCW_PNL_ALL;
         5'h01: res = MCW_PNL_FLOAT;
         5'h02: res = MCW_PNL_STORAGE;
         5'h03: res = MCW_PNL_STREAM;
         5'h04: res = MCW_PNL_UNUSED;
         5'h05: res = MCW_PNL_DAC;
         default: res = MCW_PNL_SINGLE;
      endcase
      return res;
   endfunction : panel_class

   // ****************************************
   // Declarations
   // ****************************************
   logic [15:0] ctl_ff;
   logic [15:0] cmd_ff;
   logic read_ff;
   logic sync_ff;
   logic done_ff;
   logic [3:0] cnt_ff;
   logic [3:0] nxt_cnt;
   mcw_rd_state_t rd_state_ff;
   mcw_rd_state_t nxt_rd_state;
   logic [REG_W-1:0] dreg_ff;
   logic [IAR_W-1:0] diar_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [1:0] rresp_ff;
   logic [31:0] rdata_ff;
   logic wr_take;
   logic rd_take;
   logic wr_ctl;
   logic wr_cmd;
   logic wr_rdc;
   logic go_req;
   logic done_clr;
   logic done_set;
   logic [31:0] rd_word;
   logic rd_hit;
   logic wr_hit;
   logic [31:0] status_word;

   // ****************************************
   // AXI4-Lite handshakes
   // ****************************************
   assign wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
   assign s_axi_awready = wr_take;
   assign s_axi_wready = wr_take;
   assign rd_take = s_axi_arvalid && !rvalid_ff;
   assign s_axi_arready = rd_take;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rresp = rresp_ff;
   assign s_axi_rdata = rdata_ff;

   assign wr_ctl = wr_take && (s_axi_awaddr == `MCW_OFS_CTL);
   assign wr_cmd = wr_take && (s_axi_awaddr == `MCW_OFS_CMD);
   assign wr_rdc = wr_take && (s_axi_awaddr == `MCW_OFS_RDC) && s_axi_wstrb[0];
   assign wr_hit = (s_axi_awaddr == `MCW_OFS_CTL) || (s_axi_awaddr == `MCW_OFS_CMD) ||
                   (s_axi_awaddr == `MCW_OFS_RDC);
   assign go_req = wr_rdc && s_axi_wdata[`MCW_RDC_GO];
   assign done_clr = wr_rdc && s_axi_wdata[`MCW_RDC_DONE];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= `MCW_RESP_OKAY;
      end else if (wr_take) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= wr_hit ? `MCW_RESP_OKAY : `MCW_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // ****************************************
   // Control and command word registers
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_ff <= `MCW_CTL_RST;
      end else if (wr_ctl) begin
         // Sweep, gate, overlap, channel select, margins, panel
         ctl_ff <= apply_strb(ctl_ff, s_axi_wdata, s_axi_wstrb);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_ff <= `MCW_CMD_RST;
      end else if (wr_cmd) begin
         cmd_ff <= apply_strb(cmd_ff, s_axi_wdata, s_axi_wstrb);
      end
   end

   // Clock-margin bits pass as written; CPU honours them only with adjust set
   assign maint_control_word = ctl_ff;

   // Read and sync belong to the sequencer, never to software
   always_comb begin
      maint_command_word = cmd_ff;
      maint_command_word[`MCW_CMD_READ] = read_ff;
      maint_command_word[`MCW_CMD_SYNC] = sync_ff;
   end

   // ****************************************
   // Display register read sequencer
   // ****************************************
   always_comb begin
      nxt_rd_state = rd_state_ff;
      nxt_cnt = cnt_ff;
      case (rd_state_ff)
         MCW_RD_IDLE: begin
            if (go_req) begin
               nxt_rd_state = MCW_RD_STROBE;
               nxt_cnt = `MCW_READ_SETUP;
            end
         end
         MCW_RD_STROBE: begin
            if (cnt_ff == 4'h1) begin
               nxt_rd_state = MCW_RD_SYNC;
               nxt_cnt = `MCW_SYNC_HOLD;
            end else begin
               nxt_cnt = cnt_ff - 4'h1;
            end
         end
         MCW_RD_SYNC: begin
            if (cnt_ff == 4'h1) begin
               nxt_rd_state = MCW_RD_CAPTURE;
            end else begin
               nxt_cnt = cnt_ff - 4'h1;
            end
         end
         MCW_RD_CAPTURE: begin
            nxt_rd_state = MCW_RD_RELEASE;
         end
         MCW_RD_RELEASE: begin
            nxt_rd_state = MCW_RD_IDLE;
         end
         default: begin
            nxt_rd_state = MCW_RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_ff <= MCW_RD_IDLE;
         cnt_ff <= 4'h0;
      end else begin
         rd_state_ff <= nxt_rd_state;
         cnt_ff <= nxt_cnt;
      end
   end

   // Read up before sync, sync dropped before read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         read_ff <= 1'b0;
         sync_ff <= 1'b0;
      end else begin
         read_ff <= (nxt_rd_state != MCW_RD_IDLE) && (nxt_rd_state != MCW_RD_RELEASE);
         sync_ff <= (nxt_rd_state == MCW_RD_SYNC);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dreg_ff <= '0;
         diar_ff <= '0;
      end else if (rd_state_ff == MCW_RD_CAPTURE) begin
         dreg_ff <= disp_reg_data;
         diar_ff <= current_instr_address;
      end
   end

   assign done_set = (rd_state_ff == MCW_RD_RELEASE);

   // Completion flag: a set in the clear cycle wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         done_ff <= 1'b0;
      end else if (done_set) begin
         done_ff <= 1'b1;
      end else if (done_clr) begin
         done_ff <= 1'b0;
      end
   end

   // ****************************************
   // Register read path
   // ****************************************
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`MCW_RDC_BUSY] = (rd_state_ff != MCW_RD_IDLE);
      status_word[`MCW_RDC_DONE] = done_ff;
      status_word[`MCW_RDC_CHSEL_LSB +: 2] =
         mcw_chsel_t'(ctl_ff[`MCW_CTL_CHSEL_LSB +: 2]);
      status_word[`MCW_RDC_PANEL_LSB +: 3] =
         panel_class(ctl_ff[`MCW_CTL_PANEL_LSB +: 5]);
   end

   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit = 1'b1;
      case (s_axi_araddr)
         `MCW_OFS_CTL: rd_word = {16'h0000, ctl_ff};
         `MCW_OFS_CMD: rd_word = {16'h0000, maint_command_word};
         `MCW_OFS_RDC: rd_word = status_word;
         `MCW_OFS_DREG: rd_word[REG_W-1:0] = dreg_ff;
         `MCW_OFS_DIAR: rd_word[IAR_W-1:0] = diar_ff;
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rresp_ff <= `MCW_RESP_OKAY;
         rdata_ff <= 32'h0000_0000;
      end else if (rd_take) begin
         rvalid_ff <= 1'b1;
         rresp_ff <= rd_hit ? `MCW_RESP_OKAY : `MCW_RESP_SLVERR;
         rdata_ff <= rd_word;
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

endmodule : mcw_host
`default_nettype wire

// ==== sim/mcw_host_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module mcw_host_checker (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset, low
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   input wire logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   input wire logic [31:0] s_axi_rdata, // Read data
   input wire logic [1:0] s_axi_rresp, // Read response
   input wire logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic [15:0] maint_command_word, // Command word
   input wire logic [15:0] maint_control_word // Control word
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence sync_hold;
      maint_command_word[6] [*2];
   endsequence
   sequence capture_end;
      !maint_command_word[6] && maint_command_word[4] ##1 !maint_command_word[4];
   endsequence
   a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
      else $error("write answer late");
   a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
      else $error("read answer late");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
      else $error("read data moved");
   a_unmapped_err: assert property (s_axi_arvalid && !s_axi_rvalid && s_axi_araddr >= 8'h14
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
   a_ctl_update: assert property (
      s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && s_axi_awaddr == 8'h00 && s_axi_wstrb == 4'hf
      |=> maint_control_word == $past(s_axi_wdata[15:0])) else $error("control word not updated");
   a_read_setup: assert property ($rose(maint_command_word[4])
      |-> (!maint_command_word[6]) [*2] ##1 maint_command_word[6]) else $error("sync timing");
   a_read_frame: assert property ($rose(maint_command_word[6]) |-> sync_hold ##1 capture_end)
      else $error("read frame wrong");
   a_sync_read: assert property (maint_command_word[6] |-> maint_command_word[4])
      else $error("sync without read");
endmodule : mcw_host_checker
bind mcw_host mcw_host_checker chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_wdata,
   .s_axi_wstrb, .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .maint_command_word,
   .maint_control_word);
`default_nettype wire

// ==== sim/mcw_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module mcw_cpu_model #(
   parameter logic [27:0] REG_BASE = 28'h5a0c3e9,
   parameter logic [31:0] IAR_VAL = 32'h0002_4680
) (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset, low
   input wire logic [15:0] maint_command_word, // Command word
   input wire logic [15:0] maint_control_word, // Control word
   output logic [31:0] disp_reg_data, // Selected register
   output logic [31:0] current_instr_address // Instruction address
);
   logic seen_ff;
   logic [2:0] exec_mode;
   logic [1:0] chan_sel, freq_step, edge_shift;
   logic odd_only;
   logic [4:0] panel_sel;
   always_ff @(posedge aclk) begin
      if (!aresetn || !maint_command_word[4])
         seen_ff <= 1'b0;
      else if (maint_command_word[6])
         seen_ff <= 1'b1;
   end
   assign disp_reg_data = seen_ff ? {REG_BASE, maint_command_word[3:0]}
      : ~{REG_BASE, maint_command_word[3:0]};
   assign current_instr_address = seen_ff ? IAR_VAL : ~IAR_VAL;
   assign exec_mode = maint_control_word[15:13];
   assign chan_sel = maint_control_word[12:11];
   assign freq_step = maint_control_word[10] ? maint_control_word[9:8] : 2'h0;
   assign edge_shift = maint_control_word[10] ? maint_control_word[7:6] : 2'h0;
   assign odd_only = &maint_control_word[7:5];
   assign panel_sel = maint_control_word[4:0];
endmodule : mcw_cpu_model
`default_nettype wire

// ==== sim/mcw_host_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module mcw_host_test;
   localparam logic [27:0] REG_BASE = 28'h5a0c3e9;
   localparam logic [31:0] IAR_VAL = 32'h0002_4680;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata, disp_reg_data, current_instr_address, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] maint_command_word, maint_control_word;
   int failures = 0;
   int compares = 0;
   int i;
   mcw_host dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .maint_command_word, .maint_control_word,
      .disp_reg_data, .current_instr_address);
   mcw_cpu_model #(.REG_BASE(REG_BASE), .IAR_VAL(IAR_VAL)) cpu (.aclk, .aresetn,
      .maint_command_word, .maint_control_word, .disp_reg_data, .current_instr_address);
   task stop_test;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task tick(inout int n);
      @(negedge aclk);
      n++;
      if (n > 200) begin
         failures++;
         stop_test();
      end
   endtask : tick
   task wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do tick(n); while (!s_axi_awready);
      @(posedge aclk);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do tick(n); while (!s_axi_bvalid);
      chk({30'h0, s_axi_bresp}, {30'h0, er});
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do tick(n); while (!s_axi_arready);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      do tick(n); while (!s_axi_rvalid);
      d = s_axi_rdata;
      chk({30'h0, s_axi_rresp}, {30'h0, er});
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask : rd
   // Answers must stand while the ready signals are held low
   task stall(input logic [7:0] a, input logic [31:0] v);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do tick(n); while (!s_axi_awready);
      @(posedge aclk);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      repeat (3) tick(n);
      chk({31'h0, s_axi_bvalid}, 32'h1);
      chk({30'h0, s_axi_bresp}, 32'h0);
      @(posedge aclk);
      s_axi_bready <= 1'b1;
      do tick(n); while (!s_axi_bvalid);
      @(posedge aclk);
      s_axi_bready <= 1'b0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do tick(n); while (!s_axi_arready);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      repeat (3) tick(n);
      chk({31'h0, s_axi_rvalid}, 32'h1);
      chk(s_axi_rdata, v);
      @(posedge aclk);
      s_axi_rready <= 1'b1;
      do tick(n); while (!s_axi_rvalid);
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask : stall
   task go(input logic [3:0] r);
      int n;
      wr(8'h04, {28'h0, r}, 4'hf, 2'h0);
      wr(8'h08, 32'h1, 4'hf, 2'h0);
      n = 0;
      do begin
         rd(8'h08, 2'h0);
         n++;
      end while (d[1] !== 1'b1 && n < 20);
      chk({30'h0, d[1:0]}, 32'h2);
      rd(8'h0c, 2'h0);
      chk(d, {REG_BASE, r});
      rd(8'h10, 2'h0);
      chk(d, IAR_VAL);
      wr(8'h08, 32'h2, 4'hf, 2'h0);
      rd(8'h08, 2'h0);
      chk({31'h0, d[1]}, 32'h0);
   endtask : go
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_wstrb} <= '0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h00, 2'h0);
      chk(d, 32'h0);
      rd(8'h04, 2'h0);
      chk(d, 32'h0);
      for (i = 0; i < 16; i++) begin
         wr(8'h00, 32'h1 << i, 4'hf, 2'h0);
         chk({16'h0, maint_control_word}, 32'h1 << i);
      end
      for (i = 0; i < 4; i++) begin
         wr(8'h00, i << 11, 4'hf, 2'h0);
         rd(8'h08, 2'h0);
         chk({30'h0, d[5:4]}, i);
      end
      for (i = 0; i < 8; i++) begin
         wr(8'h00, (i < 7) ? i : 31, 4'hf, 2'h0);
         rd(8'h08, 2'h0);
         chk({29'h0, d[10:8]}, (i < 6) ? i : 6);
      end
      wr(8'h00, 32'hffff, 4'hf, 2'h0);
      wr(8'h00, 32'ha5c3, 4'h1, 2'h0);
      chk({16'h0, maint_control_word}, 32'hffc3);
      wr(8'h04, 32'hffff, 4'hf, 2'h0);
      rd(8'h04, 2'h0);
      chk(d, 32'hffaf);
      stall(8'h00, 32'h0000_1234);
      go(4'h0);
      go(4'h9);
      go(4'hf);
      wr(8'h00, 32'hf6e5, 4'hf, 2'h0);
      chk({29'h0, cpu.exec_mode}, 32'h7);
      chk({30'h0, cpu.chan_sel}, 32'h2);
      chk({30'h0, cpu.freq_step}, 32'h2);
      chk({30'h0, cpu.edge_shift}, 32'h3);
      chk({31'h0, cpu.odd_only}, 32'h1);
      chk({27'h0, cpu.panel_sel}, 32'h5);
      wr(8'h00, 32'hf2e5, 4'hf, 2'h0);
      chk({28'h0, cpu.freq_step, cpu.edge_shift}, 32'h0);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h00, 2'h0);
      chk(d, 32'h0);
      chk({16'h0, maint_control_word}, 32'h0);
      rd(8'h0c, 2'h0);
      chk(d, 32'h0);
      wr(8'h20, 32'h1, 4'hf, 2'h2);
      rd(8'h20, 2'h2);
      chk(d, 32'h0);
      stop_test();
   end
endmodule : mcw_host_test
`default_nettype wire
